// ===== power_seq_pkg.sv
package power_seq_pkg;

  // ==========================================================================
  // Register map (APB, byte addresses, one aligned word each)
  // ==========================================================================
  localparam logic [7:0] CTRL_ADDR   = 8'h00;  // Control register
  localparam logic [7:0] STATUS_ADDR = 8'h04;  // Status register
  localparam logic [7:0] RTC_ADDR    = 8'h08;  // RTC time counter (read)
  localparam logic [7:0] ALARM_ADDR  = 8'h0c;  // RTC alarm value

  // Control register fields
  localparam int CTRL_PSV_BIT      = 0;  // Power saving enable
  localparam int CTRL_GREET_BIT    = 1;  // Greeting text enable
  localparam int CTRL_FIXBAUD_BIT  = 2;  // Serial port at fixed baud rate
  localparam int CTRL_ALARM_EN_BIT = 3;  // RTC alarm armed
  localparam int CTRL_OFF_BIT      = 4;  // Software switch-off request
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;  // All off after power-up

  // Status register fields
  localparam int ST_VINT_BIT   = 0;  // Interface supply on
  localparam int ST_RSTN_BIT   = 1;  // Internal reset released
  localparam int ST_READY_BIT  = 2;  // Ready to operate
  localparam int ST_ACTIVE_BIT = 3;  // Active mode (26 MHz clock)
  localparam int ST_IDLE_BIT   = 4;  // Low power idle mode
  localparam int ST_BCKP_BIT   = 5;  // Backup supply enabled
  localparam int ST_GREET_BIT  = 6;  // Greeting text sent (sticky)
  localparam int ST_STATE_LSB  = 8;  // Sequencer state code

  // ==========================================================================
  // Timing (system clock 20 MHz)
  // ==========================================================================
  localparam int CLK_HZ          = 20_000_000;
  localparam int RESET_HOLD_US   = 10;  // Internal reset hold after supply up
  localparam int RESET_HOLD_CYC  = (RESET_HOLD_US * (CLK_HZ / 1_000_000));
  localparam int PIN_STEP_CYC    = 4;   // Cycles between pin configuration steps
  localparam int IDLE_WAIT_CYC   = 64;  // Quiet cycles before idle entry
  localparam int PAGE_CYC        = 256; // Paging monitor period
  localparam int PAGE_ON_CYC     = 8;   // Receiver on time per paging block
  localparam int RTC_TICK_CYC    = 20;  // System cycles per RTC tick

  localparam int CNT_W = 16;

  // ==========================================================================
  // Sequencer states, one-hot
  // ==========================================================================
  typedef enum logic [5:0] {
    ST_NOPWR  = 6'b000001,  // Main supply absent
    ST_OFF    = 6'b000010,  // Power-off, supply valid
    ST_RST    = 6'b000100,  // Interface supply on, internal reset held
    ST_PINCFG = 6'b001000,  // Pins stepping to default configuration
    ST_USBCFG = 6'b010000,  // Waiting for USB enumeration
    ST_READY  = 6'b100000   // Ready to operate
  } seq_state_t;

  // Control bits carried together
  typedef struct packed {
    logic psv_en;     // Power saving enable
    logic greet_en;   // Greeting text enable
    logic fix_baud;   // Fixed baud rate
    logic alarm_en;   // Alarm armed
  } ctrl_t;

endpackage

// ===== module_power_on_sequencer.sv
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
// Behaviour
// - Power saving off: never enter idle
// - Power saving resets off, host can clear
// - Power saving off: core on 26 MHz
// - Registered, no saving: active, periodic paging receive
// - Backup supply on while main supply valid
// - RTC gives alarm wake-ups
// - RTC counts while backup supply valid
// - No switch-on without valid main supply
// - Interface supply on exactly while switched on
// - Inputs held low at supply rise: wait release
// - Power-on low pulse release starts switch-on
// - Reset input rising edge starts switch-on
// - RTC alarm expiry starts switch-on
// - Supply valid: backup on, inputs pulled high
// - Digital pins tri-stated until interface supply on
// - Internal reset held during start-up
// - Pins configured in order, USB later
// - Ready only after all interfaces configured
// - Greeting sent when ready with fixed baud
module module_power_on_sequencer
  import power_seq_pkg::*;
#(
  parameter int N_PINS    = 8,                // Digital pins configured in order
  parameter int HOLD_CYC  = RESET_HOLD_CYC    // Internal reset hold length
) (
  input  wire logic              sys_clk_i,          // 20 MHz clock
  input  wire logic              resetn_i,           // Sync reset, active low
  input  wire logic              psel,               // APB select
  input  wire logic              penable,            // APB enable
  input  wire logic              pwrite,             // APB write
  input  wire logic [7:0]        paddr,              // APB byte address
  input  wire logic [31:0]       pwdata,             // APB write data
  output logic      [31:0]       prdata,             // APB read data
  output logic                   pready,             // APB ready
  output logic                   pslverr,            // APB error
  input  wire logic              vcc_valid_i,        // Main supply in range
  input  wire logic              bckp_valid_i,       // Backup supply in range
  input  wire logic              power_on_request_n_i, // Power-on input
  input  wire logic              reset_req_n_i,      // Reset input
  input  wire logic              registered_i,       // Registered on network
  input  wire logic              busy_i,             // Core has work pending
  input  wire logic              usb_enum_done_i,    // USB enumeration finished
  output logic                   rtc_backup_supply_o, // Backup supply enable
  output logic                   vint_en_o,          // 1.8 V I/O supply enable
  output logic                   core_rst_n_o,       // Internal reset, active low
  output logic [N_PINS-1:0]      pin_oe_o,           // Pin configured (else tri)
  output logic                   clk26_sel_o,        // 1 = 26 MHz, 0 = slow clock
  output logic                   rx_on_o,            // Receiver on for paging
  output logic                   ready_o,            // Ready to operate
  output logic                   greet_o             // Greeting send pulse
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    seq_state_t        st;        // Sequencer state
    logic [2:0]        pon_s;     // Power-on sync (two flops + last)
    logic [2:0]        rst_s;     // Reset input sync (two flops + last)
    ctrl_t             ctrl;      // Control bits
    logic              off_req;   // Software switch-off pending
    logic [31:0]       alarm;     // Alarm compare value
    logic [31:0]       rtc;       // RTC count
    logic [CNT_W-1:0]  rtc_div;   // RTC tick divider
    logic [CNT_W-1:0]  cnt;       // Sequencer timer
    logic [CNT_W-1:0]  idle_cnt;  // Quiet counter
    logic [CNT_W-1:0]  page_cnt;  // Paging period counter
    logic              idle;      // Low power idle mode
    logic              greeted;   // Greeting already sent
    logic [N_PINS-1:0] pin_oe;    // Configured pins
    logic              greet;     // Greeting pulse
    logic              rx_on;     // Receiver on
    logic              pready;    // APB ready
    logic [31:0]       prdata;    // APB read data
    logic              pslverr;   // APB error
  } state_t;

  state_t s_q;  // Registered state
  state_t s_d;  // Next state

  // Address decode used by read and write paths
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == CTRL_ADDR) || (a == STATUS_ADDR) || (a == RTC_ADDR)
              || (a == ALARM_ADDR);
  endfunction

  logic pon_rise;   // Power-on release edge
  logic rst_rise;   // Reset release edge
  logic pon_hi;     // Synchronised power-on level
  logic rst_hi;     // Synchronised reset level
  logic alarm_hit;  // Alarm expiry
  logic acc;        // APB access phase
  logic [31:0] status;

  // Edge detection reads only the second sync flop and its delayed copy
  assign pon_hi    = s_q.pon_s[1];
  assign rst_hi    = s_q.rst_s[1];
  assign pon_rise  = s_q.pon_s[1] & ~s_q.pon_s[2];
  assign rst_rise  = s_q.rst_s[1] & ~s_q.rst_s[2];
  assign alarm_hit = s_q.ctrl.alarm_en && (s_q.rtc == s_q.alarm);
  assign acc       = psel && penable && !s_q.pready;

  // Status word built from live state
  always_comb begin
    status = '0;
    status[ST_VINT_BIT]   = (s_q.st != ST_NOPWR) && (s_q.st != ST_OFF);
    status[ST_RSTN_BIT]   = s_q.st inside {ST_PINCFG, ST_USBCFG, ST_READY};
    status[ST_READY_BIT]  = (s_q.st == ST_READY);
    status[ST_ACTIVE_BIT] = status[ST_VINT_BIT] && !s_q.idle;
    status[ST_IDLE_BIT]   = s_q.idle;
    status[ST_BCKP_BIT]   = vcc_valid_i;
    status[ST_GREET_BIT]  = s_q.greeted;
    status[ST_STATE_LSB +: 6] = s_q.st;
  end

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    s_d         = s_q;
    s_d.greet   = 1'b0;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    // Two-flop synchronisers, third flop for edge detection
    s_d.pon_s = {s_q.pon_s[1:0], power_on_request_n_i};
    s_d.rst_s = {s_q.rst_s[1:0], reset_req_n_i};

    // RTC runs whenever the backup rail is good, with or without main supply
    if (bckp_valid_i) begin
      if (s_q.rtc_div == CNT_W'(RTC_TICK_CYC - 1)) begin
        s_d.rtc_div = '0;
        s_d.rtc     = s_q.rtc + 32'h1;
      end else begin
        s_d.rtc_div = s_q.rtc_div + 1'b1;
      end
    end

    // APB slave: answer one cycle into the access phase
    if (acc) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = !addr_ok(paddr);
      s_d.prdata  = '0;
      if (pwrite) begin
        case (paddr)
          CTRL_ADDR: begin
            // Host may turn saving on or off at any time
            s_d.ctrl.psv_en   = pwdata[CTRL_PSV_BIT];
            s_d.ctrl.greet_en = pwdata[CTRL_GREET_BIT];
            s_d.ctrl.fix_baud = pwdata[CTRL_FIXBAUD_BIT];
            s_d.ctrl.alarm_en = pwdata[CTRL_ALARM_EN_BIT];
            s_d.off_req       = pwdata[CTRL_OFF_BIT];
          end
          ALARM_ADDR: s_d.alarm = pwdata;
          default: begin
          end
        endcase
      end else begin
        case (paddr)
          CTRL_ADDR:   s_d.prdata = {27'h0, s_q.off_req, s_q.ctrl.alarm_en,
                                     s_q.ctrl.fix_baud, s_q.ctrl.greet_en,
                                     s_q.ctrl.psv_en};
          STATUS_ADDR: s_d.prdata = status;
          RTC_ADDR:    s_d.prdata = s_q.rtc;
          ALARM_ADDR:  s_d.prdata = s_q.alarm;
          default:     s_d.prdata = '0;
        endcase
      end
    end

    // Sequencer
    case (s_q.st)
      ST_NOPWR: begin
        s_d.pin_oe = '0;
        // Supply up: wait until both pulled-up inputs read high
        if (vcc_valid_i && pon_hi && rst_hi) begin
          s_d.st  = ST_RST;
          s_d.cnt = '0;
        end
      end
      ST_OFF: begin
        s_d.pin_oe = '0;
        if (!vcc_valid_i) begin
          s_d.st = ST_NOPWR;
        end else if (pon_rise || rst_rise || alarm_hit) begin
          s_d.st            = ST_RST;
          s_d.cnt           = '0;
          s_d.ctrl.alarm_en = 1'b0;  // One-shot alarm
        end
      end
      ST_RST: begin
        // Internal reset held while interface supply settles
        if (s_q.cnt == CNT_W'(HOLD_CYC - 1)) begin
          s_d.st  = ST_PINCFG;
          s_d.cnt = '0;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      ST_PINCFG: begin
        // One pin per step so outputs do not all switch together
        if (s_q.cnt == CNT_W'(PIN_STEP_CYC - 1)) begin
          s_d.cnt    = '0;
          s_d.pin_oe = {s_q.pin_oe[N_PINS-2:0], 1'b1};
          if (s_q.pin_oe[N_PINS-2]) begin
            s_d.st = ST_USBCFG;
          end
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      ST_USBCFG: begin
        // USB enumeration can take arbitrarily long
        if (usb_enum_done_i) begin
          s_d.st = ST_READY;
        end
      end
      ST_READY: begin
        // Greeting only makes sense at a known baud rate
        if (!s_q.greeted && s_q.ctrl.greet_en && s_q.ctrl.fix_baud) begin
          s_d.greet   = 1'b1;
          s_d.greeted = 1'b1;
        end
      end
      default: s_d.st = ST_NOPWR;
    endcase

    // Switch-off paths common to all on states
    if (s_q.st inside {ST_RST, ST_PINCFG, ST_USBCFG, ST_READY}) begin
      if (!vcc_valid_i) begin
        s_d.st = ST_NOPWR;
      end else if (s_q.off_req || !rst_hi) begin
        s_d.st      = ST_OFF;
        s_d.off_req = 1'b0;
      end
      if (s_d.st inside {ST_OFF, ST_NOPWR}) begin
        s_d.greet   = 1'b0;  // No greeting pulse once the device leaves ready
        s_d.pin_oe  = '0;
        s_d.greeted = 1'b0;
        s_d.idle    = 1'b0;
        s_d.rx_on   = 1'b0;
      end
    end

    // Power management while ready
    if (s_q.st == ST_READY && s_d.st == ST_READY) begin
      if (!s_q.ctrl.psv_en || busy_i) begin
        s_d.idle     = 1'b0;
        s_d.idle_cnt = '0;
      end else if (s_q.idle_cnt == CNT_W'(IDLE_WAIT_CYC - 1)) begin
        s_d.idle = 1'b1;
      end else begin
        s_d.idle_cnt = s_q.idle_cnt + 1'b1;
      end
      // Paging monitor: receiver pulsed each period while registered
      if (registered_i) begin
        if (s_q.page_cnt == CNT_W'(PAGE_CYC - 1)) begin
          s_d.page_cnt = '0;
        end else begin
          s_d.page_cnt = s_q.page_cnt + 1'b1;
        end
        s_d.rx_on = (s_q.page_cnt >= CNT_W'(PAGE_CYC - PAGE_ON_CYC - 1))
                    && (s_q.page_cnt != CNT_W'(PAGE_CYC - 1));
      end else begin
        s_d.rx_on    = 1'b0;
        s_d.page_cnt = '0;
      end
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      s_q         <= '0;
      s_q.st      <= ST_NOPWR;
      s_q.pon_s   <= 3'h7;
      s_q.rst_s   <= 3'h7;
      s_q.ctrl    <= ctrl_t'(CTRL_RESET[3:0]);
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs, all registered
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rtc_backup_supply_o <= 1'b0;
      vint_en_o           <= 1'b0;
      core_rst_n_o        <= 1'b0;
      clk26_sel_o         <= 1'b0;
    end else begin
      rtc_backup_supply_o <= vcc_valid_i;
      vint_en_o    <= s_d.st inside {ST_RST, ST_PINCFG, ST_USBCFG, ST_READY};
      core_rst_n_o <= s_d.st inside {ST_PINCFG, ST_USBCFG, ST_READY};
      clk26_sel_o  <= (s_d.st != ST_NOPWR) && (s_d.st != ST_OFF) && !s_d.idle;
    end
  end

  assign pin_oe_o = s_q.pin_oe;
  assign rx_on_o  = s_q.rx_on;
  assign ready_o  = (s_q.st == ST_READY);
  assign greet_o  = s_q.greet;
  assign prdata   = s_q.prdata;
  assign pready   = s_q.pready;
  assign pslverr  = s_q.pslverr;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence seq_off_ok;
    s_q.st == ST_OFF && vcc_valid_i;
  endsequence
  sequence seq_pon_edge;
    pon_rise;
  endsequence

  chk_no_idle_psv: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !s_q.ctrl.psv_en |-> ##1 !s_q.idle)
    else $error("idle entered with saving off");
  chk_clk_fast: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (s_q.st == ST_READY && !s_q.ctrl.psv_en) ##1 (s_q.st == ST_READY) |-> clk26_sel_o)
    else $error("slow clock with saving off");
  chk_bckp_follow: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    vcc_valid_i |=> rtc_backup_supply_o)
    else $error("backup supply off with main valid");
  chk_no_on_novcc: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !vcc_valid_i |=> !vint_en_o)
    else $error("switched on without supply");
  chk_vint_state: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    vint_en_o == status[ST_VINT_BIT])
    else $error("interface supply mismatch");
  chk_pon_start: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    seq_off_ok and seq_pon_edge |=> s_q.st == ST_RST)
    else $error("power-on release ignored");
  chk_pins_tri: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !vint_en_o |-> pin_oe_o == '0)
    else $error("pin driven without supply");
  chk_rst_hold: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    $rose(vint_en_o) |-> !core_rst_n_o [*2])
    else $error("internal reset released early");
  chk_ready_pins: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    ready_o |-> (&pin_oe_o) && core_rst_n_o)
    else $error("ready before configuration");
  chk_greet_baud: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    greet_o |-> ready_o && s_q.ctrl.fix_baud)
    else $error("greeting without fixed baud");

  // Other switch-on causes from power-off, same one-cycle response as power-on
  chk_rst_start: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (s_q.st == ST_OFF) && vcc_valid_i && rst_rise |=> s_q.st == ST_RST)
    else $error("reset input release ignored");
  chk_alarm_start: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (s_q.st == ST_OFF) && vcc_valid_i && alarm_hit |=> s_q.st == ST_RST)
    else $error("alarm expiry ignored");

  // Enabled pins always form one run from bit 0, so the order is kept
  chk_pin_order: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (pin_oe_o & (pin_oe_o + N_PINS'(1))) == '0)
    else $error("pins configured out of order");

  // Ready may only follow a finished enumeration
  chk_ready_usb: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    $rose(ready_o) |-> $past(usb_enum_done_i))
    else $error("ready before enumeration");

  // Receiver stays off when there is no network to page from
  chk_rx_unreg: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !registered_i |=> !rx_on_o)
    else $error("receiver on while unregistered");

endmodule

// ===== host_pin_model.sv
`timescale 1ns/1ps
// ============================================================
// Host side: supplies, pulled-up control pins, USB enumeration
module host_pin_model (
  input  wire logic sys_clk_i,            // Bench clock
  input  wire logic core_rst_n_i,         // Device internal reset
  output logic      vcc_valid_o,          // Main supply valid
  output logic      bckp_valid_o,         // Backup supply valid
  output logic      power_on_request_n_o, // Power-on line
  output logic      reset_req_n_o,        // Reset line
  output logic      usb_enum_done_o       // Enumeration finished
);
  int usb_delay = 0;  // Enumeration time, 0 answers promptly
  int usb_cnt   = 0;  // Cycles since internal reset release

  // Idle lines sit at the pull-up level; main supply starts absent, backup present
  initial begin
    vcc_valid_o          = 1'b0;
    bckp_valid_o         = 1'b1;
    power_on_request_n_o = 1'b1;
    reset_req_n_o        = 1'b1;
    usb_enum_done_o      = 1'b0;
  end

  // Supply change, optionally holding the power-on line low through the rise
  task automatic supply(input logic v, input logic hold_low);
    @(posedge sys_clk_i);
    // Line goes low first so its synchronised level reads low at the rise
    if (hold_low) power_on_request_n_o <= 1'b0;
    if (hold_low) repeat (3) @(posedge sys_clk_i);
    vcc_valid_o <= v;
  endtask

  // Release after a held supply rise; host sees start on the I/O supply
  task automatic release_on();
    @(posedge sys_clk_i);
    power_on_request_n_o <= 1'b1;
  endtask

  // Low pulse on one line, released back to the pull-up level
  task automatic pulse(input logic on_rst, input int n);
    @(posedge sys_clk_i);
    if (on_rst) reset_req_n_o <= 1'b0;
    else power_on_request_n_o <= 1'b0;
    repeat (n) @(posedge sys_clk_i);
    power_on_request_n_o <= 1'b1;
    reset_req_n_o        <= 1'b1;
  endtask

  // Enumeration ends usb_delay cycles after reset release; slow host delays it
  always @(posedge sys_clk_i) begin
    if (core_rst_n_i !== 1'b1) begin
      usb_cnt         <= 0;
      usb_enum_done_o <= 1'b0;
    end else if (usb_cnt >= usb_delay) usb_enum_done_o <= 1'b1;
    else usb_cnt <= usb_cnt + 1;
  end
endmodule

// ===== module_power_on_sequencer_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module module_power_on_sequencer_test;
  import power_seq_pkg::*;
  typedef struct {logic [32:0] e; logic [32:0] m;} note_t; // {pslverr, prdata}, mask
  logic        sys_clk_i, resetn_i, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, pin_oe_o;
  logic [31:0] pwdata, prdata, rdata, t0;
  logic        registered_i, busy_i, vcc, bckp, pon_n, rst_n, usb;
  logic        rtc_backup_supply_o, vint_en_o, core_rst_n_o, clk26_sel_o;
  logic        rx_on_o, ready_o, greet_o;
  note_t       notes[$];
  note_t       cur;
  int          errors = 0, n_tests = 0, cyc = 0, greets = 0, rx_seen = 0;
  int          seed = 32'h1304b7ff;

  // ============================================================
  // Design and host
  // Short reset hold keeps the run brief
  module_power_on_sequencer #(.N_PINS(8), .HOLD_CYC(4)) u_module_power_on_sequencer (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vcc_valid_i(vcc), .bckp_valid_i(bckp),
    .power_on_request_n_i(pon_n), .reset_req_n_i(rst_n), .registered_i(registered_i),
    .busy_i(busy_i), .usb_enum_done_i(usb), .rtc_backup_supply_o(rtc_backup_supply_o),
    .vint_en_o(vint_en_o), .core_rst_n_o(core_rst_n_o), .pin_oe_o(pin_oe_o),
    .clk26_sel_o(clk26_sel_o), .rx_on_o(rx_on_o), .ready_o(ready_o), .greet_o(greet_o));
  host_pin_model u_host (
    .sys_clk_i(sys_clk_i), .core_rst_n_i(core_rst_n_o), .vcc_valid_o(vcc),
    .bckp_valid_o(bckp), .power_on_request_n_o(pon_n), .reset_req_n_o(rst_n),
    .usb_enum_done_o(usb));

  // ============================================================
  // Clock, hang limit, greeting count and read monitor
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // Each read note is taken off the queue when its answer shows
  always @(posedge sys_clk_i) begin
    cyc++;
    if (greet_o === 1'b1) greets++;
    if (cyc == 60000) begin
      errors++;
      conclude();
    end
    if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
      cur = notes.pop_front();
      `CHK({pslverr, prdata} & cur.m, cur.e)
    end
  end

  // ============================================================
  // Tasks
  task automatic step();
    @(posedge sys_clk_i);
    #1;
  endtask

  // One APB transfer; a read leaves its expectation in the queue
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] m);
    @(posedge sys_clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    if (!wr) notes.push_back('{e, m});
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    rdata = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Follow a switch-on from I/O supply rise to ready
  task automatic wait_on(input int lim);
    int i;
    for (i = 0; i < lim && vint_en_o !== 1'b1; i++) step();
    `CHK(vint_en_o, 1'b1)
    `CHK({core_rst_n_o, pin_oe_o}, 9'h000)
    for (i = 0; i < 3000 && ready_o !== 1'b1; i++) begin
      step();
      `CHK(pin_oe_o & (pin_oe_o + 8'h01), 8'h00)
      if (core_rst_n_o !== 1'b1) `CHK(pin_oe_o, 8'h00)
    end
    `CHK({ready_o, pin_oe_o, usb}, 10'h3ff)
  endtask

  // Software switch-off, then the request bit is cleared again
  task automatic switch_off(input logic [31:0] ctrl);
    int i;
    apb(1'b1, CTRL_ADDR, ctrl | 32'h10, '0, '0);
    for (i = 0; i < 50 && vint_en_o !== 1'b0; i++) step();
    `CHK({vint_en_o, ready_o, pin_oe_o}, 10'h000)
    apb(1'b1, CTRL_ADDR, ctrl, '0, '0);
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ============================================================
  // Main sequence
  initial begin
    resetn_i     = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 8'h00;
    pwdata       = 32'h0;
    registered_i = 1'b0;
    busy_i       = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    step();
    `CHK({vint_en_o, ready_o, rtc_backup_supply_o}, 3'b000)
    apb(1'b0, CTRL_ADDR, '0, 33'h0, '1);
    apb(1'b0, 8'h10, '0, 33'h1_0000_0000, '1); // Unmapped word is refused
    // Supply rises with the power-on line held low
    u_host.supply(1'b1, 1'b1);
    repeat (30) step();
    `CHK({vint_en_o, rtc_backup_supply_o}, 2'b01)
    u_host.release_on();
    wait_on(20);
    // Power saving off: active on the fast clock whatever the load
    registered_i <= 1'b1;
    repeat (300) begin
      step();
      busy_i <= 1'($random(seed));
      if (rx_on_o === 1'b1) rx_seen++;
      `CHK({ready_o, clk26_sel_o}, 2'b11)
    end
    `CHK(rx_seen > 0, 1'b1)
    apb(1'b0, STATUS_ADDR, '0, 33'h28, 33'h38);
    apb(1'b1, CTRL_ADDR, 32'h1, '0, '0); // Turn power saving on
    busy_i <= 1'b0;
    repeat (100) step();
    apb(1'b0, STATUS_ADDR, '0, 33'h10, 33'h18);
    `CHK(clk26_sel_o, 1'b0)
    apb(1'b1, CTRL_ADDR, 32'h6, '0, '0);
    apb(1'b0, CTRL_ADDR, '0, 33'h6, 33'h7);
    repeat (70) step();
    apb(1'b0, STATUS_ADDR, '0, 33'h8, 33'h18);
    `CHK(greets, 1)
    // Wake by power-on pulse with greeting at fixed baud
    switch_off(32'h6);
    u_host.pulse(1'b0, 3 + ($random(seed) & 7));
    wait_on(40);
    repeat (3) step();
    `CHK(greets, 2)
    // Wake by reset release, greeting without fixed baud, slow USB
    switch_off(32'h2);
    u_host.usb_delay = 40;
    u_host.pulse(1'b1, 5);
    wait_on(40);
    repeat (3) step();
    `CHK(greets, 2)
    // Wake by alarm a few ticks ahead
    switch_off(32'h0);
    apb(1'b0, RTC_ADDR, '0, 33'h0, 33'h1_0000_0000);
    t0 = rdata;
    apb(1'b1, ALARM_ADDR, t0 + 32'h3 + 32'($random(seed) & 1), '0, '0);
    apb(1'b1, CTRL_ADDR, 32'h8, '0, '0);
    wait_on(200);
    apb(1'b0, RTC_ADDR, '0, 33'h0, 33'h1_0000_0000);
    `CHK(rdata > t0 + 32'h2, 1'b1)
    t0 = rdata;
    // Main supply lost: no switch-on possible
    u_host.supply(1'b0, 1'b0);
    repeat (5) step();
    `CHK({rtc_backup_supply_o, vint_en_o, ready_o}, 3'b000)
    u_host.pulse(1'b0, 6);
    repeat (40) step();
    `CHK(vint_en_o, 1'b0)
    apb(1'b0, RTC_ADDR, '0, 33'h0, 33'h1_0000_0000);
    `CHK(rdata > t0, 1'b1)
    conclude();
  end
endmodule
